// [inc/lpc_pkg.sv]
// constants for the long pause command handler
// Operation
// RULE_01: accepted command enters pause until watchdog expiry
// RULE_02: watchdog expiry in pause enters sleep
// RULE_03: paused device ignores all wire activity
// RULE_04: opcode 0x01, no data bytes
// RULE_05: host sends second parameter as zero
// RULE_06: zero selector pauses all, no response
// RULE_07: nonzero selector compares fuses 84-87 low nibble
// RULE_08: unselected device answers error byte 0x0F
// RULE_09: paused device never sends a response
// RULE_10: wire only pulled low, external pull-up
package lpc_pkg;
	localparam logic [7:0]  LPC_OPCODE     = 8'h01;
	localparam logic [7:0]  LPC_SEL_ALL    = 8'h00;
	localparam logic [7:0]  LPC_ERR_CODE   = 8'h0F;
	localparam logic [15:0] LPC_PARAM2_VAL = 16'h0000;
	localparam int          LPC_FUSE_LO    = 84;
	localparam int          LPC_FUSE_HI    = 87;
	typedef enum logic [1:0] {LPC_ACTIVE, LPC_PAUSE, LPC_SLEEP} lpc_state_t;
endpackage : lpc_pkg

// [rtl/lpc_long_pause.sv]
// long pause command handler with wire gating and error response
`timescale 1ns/10ps
module lpc_long_pause (
	input  wire logic                  sys_clk_i,
	input  wire logic                  reset_n_i,
	input  wire logic                  clk_en_i,
	input  wire logic                  cmd_valid_i,
	input  wire logic [7:0]            cmd_opcode_i,
	input  wire logic [7:0]            cmd_selector_i,
	input  wire logic [15:0]           cmd_param2_i,
	input  wire logic [3:0]            fuse_sel_i,
	input  wire logic                  wdt_expire_i,
	input  wire logic                  wake_i,
	input  wire logic                  sda_i,
	input  wire logic                  rsp_ready_i,
	output logic                       sda_o,
	output logic                       sda_oe_o,
	output logic                       sda_gated_o,
	output logic                       rsp_valid_o,
	output logic [7:0]                 rsp_data_o,
	output logic                       paused_o,
	output logic                       sleep_o,
	output lpc_pkg::lpc_state_t        state_o
);
	import lpc_pkg::*;

	logic       rst_meta_n;
	logic       rst_n;
	logic       sda_meta;
	logic       sda_sync;
	lpc_state_t state;
	lpc_state_t next_state;
	logic       next_rsp_valid;
	logic [7:0] next_rsp_data;
	logic [2:0] tx_idx;
	logic [2:0] next_tx_idx;

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_n <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n      <= rst_meta_n;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sda_meta <= 1'b1;
			sda_sync <= 1'b1;
		end else if (clk_en_i) begin
			sda_meta <= sda_i;
			sda_sync <= sda_meta;
		end
	end

	wire is_cmd    = cmd_valid_i && (state == LPC_ACTIVE);
	// RULE_04 opcode match
	wire is_pause  = is_cmd && (cmd_opcode_i == LPC_OPCODE);
	// RULE_06 broadcast selector
	wire sel_all   = (cmd_selector_i == LPC_SEL_ALL);
	// RULE_07 fuse nibble compare
	wire sel_match = (cmd_selector_i[3:0] == fuse_sel_i);
	wire go_pause  = is_pause && (sel_all || sel_match);
	// RULE_08 unselected error reply
	wire go_error  = is_pause && !sel_all && !sel_match;

	// RULE_08 error byte sent lsb first
	wire tx_bit = rsp_data_o[tx_idx];
	assign next_tx_idx = (go_error || !rsp_valid_o) ? 3'h0 : tx_idx + 3'h1;

	always_comb begin
		next_state     = state;
		next_rsp_valid = rsp_valid_o && !rsp_ready_i;
		next_rsp_data  = rsp_data_o;
		case (state)
			LPC_ACTIVE: begin
				// RULE_01 enter pause
				if (go_pause) begin
					next_state     = LPC_PAUSE;
					next_rsp_valid = 1'b0;
				end else if (go_error) begin
					next_rsp_valid = 1'b1;
					next_rsp_data  = LPC_ERR_CODE;
				end
			end
			LPC_PAUSE: begin
				// RULE_02 watchdog to sleep
				next_rsp_valid = 1'b0;
				if (wdt_expire_i)
					next_state = LPC_SLEEP;
			end
			LPC_SLEEP: begin
				next_rsp_valid = 1'b0;
				if (wake_i)
					next_state = LPC_ACTIVE;
			end
			default: begin
				next_state = LPC_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state       <= LPC_ACTIVE;
			rsp_valid_o <= 1'b0;
			rsp_data_o  <= 8'h00;
			tx_idx      <= 3'h0;
		end else if (clk_en_i) begin
			state       <= next_state;
			rsp_valid_o <= next_rsp_valid;
			rsp_data_o  <= next_rsp_data;
			tx_idx      <= next_tx_idx;
		end
	end

	// RULE_03 wire ignored while paused
	assign sda_gated_o = (state == LPC_PAUSE) ? 1'b1 : sda_sync;
	// RULE_10 pull low only
	assign sda_o       = 1'b0;
	// RULE_09 no drive while paused
	assign sda_oe_o    = rsp_valid_o && (state == LPC_ACTIVE) && !tx_bit;
	assign paused_o    = (state == LPC_PAUSE);
	assign sleep_o     = (state == LPC_SLEEP);
	assign state_o     = state;

	default clocking dc @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n);

	// RULE_01 pause on command
	pause_entry_a: assert property (clk_en_i && go_pause |=> state == LPC_PAUSE) // RULE_01
		else $error("pause not entered");
	// RULE_01 pause held until watchdog
	pause_hold_a: assert property (state == LPC_PAUSE && !(clk_en_i && wdt_expire_i) |=> state == LPC_PAUSE) // RULE_01
		else $error("pause left early");
	// RULE_02 watchdog into sleep
	sleep_entry_a: assert property (state == LPC_PAUSE && clk_en_i && wdt_expire_i |=> state == LPC_SLEEP) // RULE_02
		else $error("no sleep after watchdog");
	// RULE_03 wire masked in pause
	wire_ignored_a: assert property (state == LPC_PAUSE |-> sda_gated_o) // RULE_03
		else $error("wire seen while paused");
	// RULE_04 other opcodes ignored
	opcode_only_a: assert property (clk_en_i && is_cmd && cmd_opcode_i != LPC_OPCODE && !rsp_valid_o
		|=> !rsp_valid_o && state == LPC_ACTIVE) // RULE_04
		else $error("wrong opcode acted on");
	// RULE_06 broadcast gives no reply
	bcast_silent_a: assert property (clk_en_i && is_pause && sel_all |=> !rsp_valid_o [*2]) // RULE_06
		else $error("broadcast answered");
	// RULE_08 error reply raised
	error_reply_a: assert property (clk_en_i && go_error |=> rsp_valid_o && rsp_data_o == LPC_ERR_CODE
		&& state == LPC_ACTIVE) // RULE_08
		else $error("error reply missing");
	// RULE_07 matched selector pauses
	match_pause_a: assert property (clk_en_i && is_pause && !sel_all && sel_match |=> paused_o) // RULE_07
		else $error("matched selector not paused");
	// RULE_09 silent when not active
	paused_quiet_a: assert property (state != LPC_ACTIVE |-> !sda_oe_o && !rsp_valid_o) // RULE_09
		else $error("response while paused");
	// RULE_10 low drive only
	low_only_a: assert property (sda_oe_o |-> !sda_o) // RULE_10
		else $error("wire driven high");

	// RULE_01 frozen while disabled
	freeze_a: assert property (!clk_en_i // RULE_01
		|=> $stable(state) && $stable(rsp_valid_o) && $stable(tx_idx))
		else $error("state moved while disabled");
	// RULE_01 pause only by command
	pause_only_cmd_a: assert property (state != LPC_PAUSE && !(clk_en_i && go_pause) // RULE_01
		|=> state != LPC_PAUSE)
		else $error("pause entered without command");
	// RULE_02 sleep only from pause
	sleep_only_wdt_a: assert property (!sleep_o && !(clk_en_i && paused_o && wdt_expire_i) // RULE_02
		|=> !sleep_o)
		else $error("sleep entered without watchdog");
	// RULE_02 sleep held until wake
	sleep_hold_a: assert property (sleep_o && !(clk_en_i && wake_i) // RULE_02
		|=> sleep_o)
		else $error("sleep left without wake");

	// RULE_03 wire passed when not paused
	gated_follow_a: assert property (!paused_o // RULE_03
		|-> sda_gated_o == sda_sync)
		else $error("wire level not passed through");
	// RULE_03 commands refused while paused
	cmd_refused_a: assert property (clk_en_i && cmd_valid_i && paused_o // RULE_03
		|=> state != LPC_ACTIVE && !rsp_valid_o)
		else $error("command taken while paused");
	// RULE_03 wire stays masked in pause
	pause_wire_a: assert property (clk_en_i && paused_o && !wdt_expire_i // RULE_03
		|=> sda_gated_o && !sda_oe_o)
		else $error("wire unmasked in pause");

	// RULE_06 broadcast leaves wire idle
	bcast_wire_a: assert property (clk_en_i && is_pause && sel_all // RULE_06
		|=> paused_o && !sda_oe_o)
		else $error("broadcast drove wire");
	// RULE_09 paused device stays silent
	match_silent_a: assert property (clk_en_i && go_pause // RULE_09
		|=> !rsp_valid_o && !sda_oe_o)
		else $error("paused device answered");

	// RULE_08 first error bit released
	err_first_bit_a: assert property (clk_en_i && go_error // RULE_08
		|=> !sda_oe_o)
		else $error("error byte started low");
	// RULE_08 error high nibble pulled low
	err_wire_low_a: assert property (clk_en_i && go_error ##1 (clk_en_i && !rsp_ready_i && !is_pause) [*4] // RULE_08
		|=> sda_oe_o)
		else $error("error byte not driven low");
	// RULE_08 error held until taken
	error_kept_a: assert property (rsp_valid_o && !(clk_en_i && (rsp_ready_i || go_pause)) // RULE_08
		|=> rsp_valid_o && rsp_data_o == LPC_ERR_CODE)
		else $error("error reply dropped");
	// RULE_08 error cleared when taken
	error_clear_a: assert property (clk_en_i && rsp_valid_o && rsp_ready_i && !go_error // RULE_08
		|=> !rsp_valid_o)
		else $error("error reply not cleared");

	bcast_c: cover property (go_pause && sel_all ##[1:20] sleep_o);
	match_c: cover property (go_pause && !sel_all);
	error_c: cover property (go_error ##1 rsp_valid_o);
	wake_c: cover property (sleep_o ##1 state == LPC_ACTIVE);
	// RULE_05 zero second parameter seen
	param2_c: cover property (is_pause && cmd_param2_i == LPC_PARAM2_VAL);
endmodule // lpc_long_pause

// [test/lpc_host_model.sv]
// host controller model sharing the wire
`timescale 1ns/10ps
module lpc_host_model (
	input  wire logic        sys_clk_i,
	input  wire logic        sda_oe_i,
	input  wire logic        pull_i,
	output logic             sda_o,
	output logic             cmd_valid_o,
	output logic [7:0]       cmd_opcode_o,
	output logic [7:0]       cmd_selector_o,
	output logic [15:0]      cmd_param2_o,
	output logic             rsp_ready_o
);
	assign sda_o = ~(sda_oe_i | pull_i);
	initial begin
		{cmd_valid_o, cmd_opcode_o, cmd_selector_o, cmd_param2_o, rsp_ready_o} = '0;
	end
	task automatic send(input logic [7:0] opc, input logic [7:0] sel);
		cmd_valid_o = 1'b1;
		cmd_opcode_o = opc;
		cmd_selector_o = sel;
		cmd_param2_o = 16'h0000;
		@(negedge sys_clk_i) cmd_valid_o = 1'b0;
	endtask
	task automatic take();
		rsp_ready_o = 1'b1;
		@(negedge sys_clk_i) rsp_ready_o = 1'b0;
	endtask
endmodule // lpc_host_model

// [test/lpc_long_pause_tb.sv]
// self-checking bench for the long pause handler
`timescale 1ns/10ps
module lpc_long_pause_tb;
	import lpc_pkg::*;
	logic sys_clk_i = 1'b0, reset_n_i = 1'b0, wdt = 1'b0, wake = 1'b0, pull = 1'b0, en = 1'b1;
	logic [3:0] fuse = 4'h2;
	logic cv, sg, rv, pd, sl, so, oe, wire_lvl, rr;
	logic [7:0] op, se, rd;
	logic [15:0] p2;
	lpc_state_t st;
	int fails = 0, samples_checked = 0, cyc = 0;
	always #20 sys_clk_i = ~sys_clk_i;
	lpc_host_model lpc_host_model_inst (.sys_clk_i(sys_clk_i), .sda_oe_i(oe), .pull_i(pull), .sda_o(wire_lvl),
		.cmd_valid_o(cv), .cmd_opcode_o(op), .cmd_selector_o(se), .cmd_param2_o(p2), .rsp_ready_o(rr));
	lpc_long_pause lpc_long_pause_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(en),
		.cmd_valid_i(cv), .cmd_opcode_i(op), .cmd_selector_i(se), .cmd_param2_i(p2), .fuse_sel_i(fuse),
		.wdt_expire_i(wdt), .wake_i(wake), .sda_i(wire_lvl), .rsp_ready_i(rr), .sda_o(so), .sda_oe_o(oe),
		.sda_gated_o(sg), .rsp_valid_o(rv), .rsp_data_o(rd), .paused_o(pd), .sleep_o(sl), .state_o(st));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic conclude();
		$display("fails %0d samples_checked %0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			$display("ERROR %0t run timed out", $time);
			conclude();
		end
	end
	task automatic to_sleep_and_back();
		wdt = 1'b1;
		@(negedge sys_clk_i) wdt = 1'b0;
		chk(sl, 8'h01);
		wake = 1'b1;
		@(negedge sys_clk_i) wake = 1'b0;
		chk(pd | sl, 8'h00);
	endtask
	task automatic t_pause_all();
		lpc_host_model_inst.send(LPC_OPCODE, LPC_SEL_ALL);
		chk(pd, 8'h01);
		chk(oe, 8'h00);
		pull = 1'b1;
		wake = 1'b1;
		repeat (4) @(negedge sys_clk_i);
		chk(sg, 8'h01);
		wake = 1'b0;
		lpc_host_model_inst.send(LPC_OPCODE, 8'h13);
		pull = 1'b0;
		repeat (3) @(negedge sys_clk_i);
		chk(pd, 8'h01);
		chk(st, LPC_PAUSE);
		chk(rv, 8'h00);
		to_sleep_and_back();
	endtask
	task automatic t_error();
		lpc_host_model_inst.send(LPC_OPCODE, 8'h13);
		chk(rd, LPC_ERR_CODE);
		chk(oe, {7'h00, !LPC_ERR_CODE[0]});
		pull = 1'b1;
		repeat (4) @(negedge sys_clk_i);
		chk(sg, 8'h00);
		chk({pd, rv}, 8'h01);
		chk(oe, {7'h00, !LPC_ERR_CODE[4]});
		pull = 1'b0;
		lpc_host_model_inst.take();
		chk(rv, 8'h00);
		chk(oe, 8'h00);
		chk(so, 8'h00);
	endtask
	task automatic t_opcode();
		lpc_host_model_inst.send(8'h02, LPC_SEL_ALL);
		chk({pd, rv}, 8'h00);
		chk(st, LPC_ACTIVE);
		@(negedge sys_clk_i);
	endtask
	task automatic t_freeze();
		en = 1'b0;
		lpc_host_model_inst.send(LPC_OPCODE, LPC_SEL_ALL);
		chk(pd, 8'h00);
		chk(st, LPC_ACTIVE);
		en = 1'b1;
		@(negedge sys_clk_i);
	endtask
	task automatic t_match();
		lpc_host_model_inst.send(LPC_OPCODE, 8'h92);
		repeat (3) @(negedge sys_clk_i);
		chk({pd, rv}, 8'h02);
		to_sleep_and_back();
		fuse = 4'h3;
		lpc_host_model_inst.send(LPC_OPCODE, 8'h13);
		chk({pd, rv}, 8'h02);
		to_sleep_and_back();
		fuse = 4'h2;
	endtask
	initial begin
		repeat (2) @(negedge sys_clk_i);
		reset_n_i = 1'b1;
		repeat (4) @(negedge sys_clk_i);
		t_pause_all();
		t_error();
		t_opcode();
		t_freeze();
		t_match();
		conclude();
	end
endmodule // lpc_long_pause_tb
